// [inc/bdr_pkg.sv]
// package for the bridge diagnostic and subsystem register bank
// assumes one clock domain and dword-aligned configuration accesses
package bdr_pkg;

   // ****************************************
   // register offsets (configuration space bytes)
   // ****************************************
   localparam logic [7:0] BDR_OFS_BASE_WINDOW   = 8'h10;
   localparam logic [7:0] BDR_OFS_SUBSYS_IDENTS = 8'h84;
   localparam logic [7:0] BDR_OFS_DIAG_TWO      = 8'hc8;
   localparam logic [7:0] BDR_OFS_SUBSYS_ALIAS  = 8'hd0;

   // ****************************************
   // field positions of control_diagnostic_two, the subsystem alias and the base window
   // ****************************************
   localparam int BDR_FTS_SEP_HI   = 31;
   localparam int BDR_FTS_SEP_LO   = 24;
   localparam int BDR_FTS_SHR_HI   = 23;
   localparam int BDR_FTS_SHR_LO   = 16;
   localparam int BDR_REV_HI       = 15;
   localparam int BDR_REV_LO       = 13;
   localparam int BDR_LINK_HI      = 12;
   localparam int BDR_LINK_LO      = 8;
   localparam int BDR_UNLOCK_BIT   = 5;
   localparam int BDR_RSVD_LOW_HI  = 4;
   localparam int BDR_SUBSYS_HI    = 31;
   localparam int BDR_SUBSYS_LO    = 16;
   localparam int BDR_BASE_LO      = 12;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [31:0] BDR_DIAG_TWO_RESET  = 32'h3214_6000;
   localparam logic [7:0]  BDR_FTS_SEP_RESET   = 8'h32;
   localparam logic [7:0]  BDR_FTS_SHR_RESET   = 8'h14;
   localparam logic [2:0]  BDR_SERDES_REV      = 3'h3;
   localparam logic [4:0]  BDR_LINK_RESET      = 5'h00;
   localparam logic        BDR_UNLOCK_RESET    = 1'b0;
   localparam logic [4:0]  BDR_RSVD_LOW_RESET  = 5'h00;
   localparam logic [15:0] BDR_IDENT_RESET     = 16'h0000;
   localparam logic [19:0] BDR_BASE_RESET      = 20'h0_0000;

   // one configuration access from the upstream party
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bdr_cfg_req_s;

   // read answer, valid one cycle after the read
   typedef struct packed
   {
      logic        valid;
      logic [31:0] data;
   } bdr_cfg_rsp_s;

endpackage

// [logic/bdr_regs.sv]
// register bank: second diagnostic register, subsystem alias, base window
// assumes requests come from logic on clk; reset pins are asynchronous
//
// What this block does
// - separate clock: send count from bits 31:24
// - shared clock: send count from bits 23:16
// - bits 7:6 read zero, ignore writes
// - base window read-only while unlock clear
// - unlock set: base bits 31:12 writable
// - resettable fields default on any reset
// - alias high half updates subsystem ident
// - alias low half updates vendor ident
`timescale 1ns/1ps

module bdr_regs
   import bdr_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         fundamental_reset_pin_n,
   input  wire logic         global_reset_pin_n,
   input  wire logic         shared_refclk_config,
   input  wire bdr_cfg_req_s cfg_req,
   output bdr_cfg_rsp_s      cfg_rsp,
   output logic [7:0]        fts_send_count,
   output logic [4:0]        link_number,
   output logic [19:0]       base_window_addr,
   output logic [15:0]       subsys_ident,
   output logic [15:0]       subsys_vendor_ident
);

   // ****************************************
   // reset release
   // ****************************************
   logic raw_rst_n;
   logic rst_meta;
   logic rst_n;

   assign raw_rst_n = nrst & fundamental_reset_pin_n & global_reset_pin_n;

   always_ff @(posedge clk or negedge raw_rst_n)
   begin
      if (!raw_rst_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ****************************************
   // register state
   // ****************************************
   logic [7:0]  fts_count_separate_clock;
   logic [7:0]  fts_count_shared_clock;
   logic [4:0]  link_num;
   logic        base_window_write_unlock;
   logic [4:0]  rsvd_low;
   logic [19:0] base_addr;
   logic [15:0] ident;
   logic [15:0] vendor_ident;
   logic [7:0]  fts_out;
   bdr_cfg_rsp_s rsp;

   logic [7:0]  next_fts_sep;
   logic [7:0]  next_fts_shr;
   logic [4:0]  next_link_num;
   logic        next_unlock;
   logic [4:0]  next_rsvd_low;
   logic [19:0] next_base_addr;
   logic [15:0] next_ident;
   logic [15:0] next_vendor_ident;
   logic [7:0]  next_fts_out;
   bdr_cfg_rsp_s next_rsp;

   logic [31:0] diag_view;
   logic [31:0] merged;
   logic [31:0] rd_mux;

   assign diag_view = {fts_count_separate_clock, fts_count_shared_clock, BDR_SERDES_REV, link_num,
                       2'b00, base_window_write_unlock, rsvd_low};

   always_comb
   begin
      merged = 32'h0000_0000;
      case (cfg_req.addr)
         BDR_OFS_BASE_WINDOW   : merged = {base_addr, 12'h000};
         BDR_OFS_SUBSYS_IDENTS : merged = {ident, vendor_ident};
         BDR_OFS_DIAG_TWO      : merged = diag_view;
         BDR_OFS_SUBSYS_ALIAS  : merged = {ident, vendor_ident};
         default               : merged = 32'h0000_0000;
      endcase
      rd_mux = merged;
      // byte lanes not enabled keep their old value
      for (int i = 0; i < 4; i++)
      begin
         if (cfg_req.be[i])
         begin
            merged[i*8 +: 8] = cfg_req.wdata[i*8 +: 8];
         end
      end
   end

   always_comb
   begin
      next_fts_sep      = fts_count_separate_clock;
      next_fts_shr      = fts_count_shared_clock;
      next_link_num     = link_num;
      next_unlock       = base_window_write_unlock;
      next_rsvd_low     = rsvd_low;
      next_base_addr    = base_addr;
      next_ident        = ident;
      next_vendor_ident = vendor_ident;
      if (cfg_req.wr)
      begin
         case (cfg_req.addr)
            BDR_OFS_DIAG_TWO:
            begin
               next_fts_sep  = merged[BDR_FTS_SEP_HI:BDR_FTS_SEP_LO];
               next_fts_shr  = merged[BDR_FTS_SHR_HI:BDR_FTS_SHR_LO];
               next_link_num = merged[BDR_LINK_HI:BDR_LINK_LO];
               next_unlock   = merged[BDR_UNLOCK_BIT];
               // stored as written; zero is the programmer's duty
               next_rsvd_low = merged[BDR_RSVD_LOW_HI:0];
            end
            BDR_OFS_BASE_WINDOW:
            begin
               if (base_window_write_unlock)
               begin
                  next_base_addr = merged[31:BDR_BASE_LO];
               end
            end
            BDR_OFS_SUBSYS_ALIAS, BDR_OFS_SUBSYS_IDENTS:
            begin
               next_ident        = merged[BDR_SUBSYS_HI:BDR_SUBSYS_LO];
               next_vendor_ident = merged[BDR_SUBSYS_LO-1:0];
            end
            default:
            begin
               next_ident = ident;
            end
         endcase
      end
      next_fts_out = shared_refclk_config ? fts_count_shared_clock : fts_count_separate_clock;
      next_rsp.valid = cfg_req.rd;
      next_rsp.data  = cfg_req.rd ? rd_mux : 32'h0000_0000;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fts_count_separate_clock <= BDR_FTS_SEP_RESET;
         fts_count_shared_clock   <= BDR_FTS_SHR_RESET;
         link_num                 <= BDR_LINK_RESET;
         base_window_write_unlock <= BDR_UNLOCK_RESET;
         rsvd_low                 <= BDR_RSVD_LOW_RESET;
         base_addr                <= BDR_BASE_RESET;
         ident                    <= BDR_IDENT_RESET;
         vendor_ident             <= BDR_IDENT_RESET;
         fts_out                  <= BDR_FTS_SEP_RESET;
         rsp                      <= '0;
      end
      else
      begin
         fts_count_separate_clock <= next_fts_sep;
         fts_count_shared_clock   <= next_fts_shr;
         link_num                 <= next_link_num;
         base_window_write_unlock <= next_unlock;
         rsvd_low                 <= next_rsvd_low;
         base_addr                <= next_base_addr;
         ident                    <= next_ident;
         vendor_ident             <= next_vendor_ident;
         fts_out                  <= next_fts_out;
         rsp                      <= next_rsp;
      end
   end

   assign cfg_rsp             = rsp;
   assign fts_send_count      = fts_out;
   assign link_number         = link_num;
   assign base_window_addr    = base_addr;
   assign subsys_ident        = ident;
   assign subsys_vendor_ident = vendor_ident;

   // ****************************************
   // assertions
   // ****************************************
   logic wr_diag;
   logic wr_alias;
   logic wr_base;
   assign wr_diag  = cfg_req.wr && cfg_req.addr == BDR_OFS_DIAG_TWO;
   assign wr_alias = cfg_req.wr && cfg_req.addr == BDR_OFS_SUBSYS_ALIAS;
   assign wr_base  = cfg_req.wr && cfg_req.addr == BDR_OFS_BASE_WINDOW;

   // release edge excluded: the count register still holds its reset value there
   a_fts_separate: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && !shared_refclk_config |=> fts_send_count == $past(fts_count_separate_clock))
      else $error("separate clock count not sent");
   a_fts_shared: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && shared_refclk_config |=> fts_send_count == $past(fts_count_shared_clock))
      else $error("shared clock count not sent");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_req.rd && cfg_req.addr == BDR_OFS_DIAG_TWO |=> cfg_rsp.valid && cfg_rsp.data[7:6] == 2'b00)
      else $error("reserved diag bits not zero");
   a_base_locked: assert property (@(posedge clk) disable iff (!rst_n)
      wr_base && !base_window_write_unlock |=> $stable(base_window_addr))
      else $error("locked base window changed");
   a_base_open: assert property (@(posedge clk) disable iff (!rst_n)
      wr_base && base_window_write_unlock && (&cfg_req.be)
      |=> base_window_addr == $past(cfg_req.wdata[31:12]))
      else $error("unlocked base window not written");
   a_reset_value: assert property (@(posedge clk)
      $rose(rst_n) |-> diag_view == BDR_DIAG_TWO_RESET && subsys_ident == BDR_IDENT_RESET)
      else $error("defaults missing after reset");
   a_alias_ident: assert property (@(posedge clk) disable iff (!rst_n)
      wr_alias && cfg_req.be[3] && cfg_req.be[2] |=> subsys_ident == $past(cfg_req.wdata[31:16]))
      else $error("subsystem ident not aliased");
   a_alias_vendor: assert property (@(posedge clk) disable iff (!rst_n)
      wr_alias && cfg_req.be[1] && cfg_req.be[0] |=> subsys_vendor_ident == $past(cfg_req.wdata[15:0]))
      else $error("vendor ident not aliased");
   a_alias_read: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_req.rd && !cfg_req.wr && cfg_req.addr == BDR_OFS_SUBSYS_ALIAS
      |=> cfg_rsp.data == {subsys_ident, subsys_vendor_ident})
      else $error("alias read mismatch");
   a_diag_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_diag && (&cfg_req.be) ##1 !shared_refclk_config |=> fts_send_count == $past(cfg_req.wdata[31:24], 2))
      else $error("new separate count not used");

   c_unlock_move: cover property (@(posedge clk) disable iff (!rst_n)
      wr_base && base_window_write_unlock);
   c_alias_write: cover property (@(posedge clk) disable iff (!rst_n) wr_alias);
   c_mode_flip: cover property (@(posedge clk) disable iff (!rst_n) $rose(shared_refclk_config));

endmodule

// [tb/bdr_root_model.sv]
// upstream requester model issuing configuration accesses
// assumes bdr_regs answers a read within four cycles
`timescale 1ns/1ps

module bdr_root_model
   import bdr_pkg::*;
(
   input  wire logic         clk,
   output bdr_cfg_req_s      cfg_req,
   input  wire bdr_cfg_rsp_s cfg_rsp
);
   int gap = 0;

   initial cfg_req = '0;

   // ****************************************
   // access tasks
   // ****************************************
   // low reserved bits written zero
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] v;
      v = (a == BDR_OFS_DIAG_TWO) ? (d & 32'hffff_ffe0) : d;
      repeat (gap + 1) @(negedge clk);
      cfg_req = '{1'b1, 1'b0, a, be, v};
      @(negedge clk);
      // released lines show inverted values, not the old ones
      cfg_req = '{1'b0, 1'b0, ~a, ~be, ~v};
   endtask

   // bounded wait: ok stays low when no answer arrives
   task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output bit ok);
      ok = 1'b0;
      d = 32'h0000_0000;
      repeat (gap + 1) @(negedge clk);
      cfg_req = '{1'b0, 1'b1, a, 4'hf, 32'h0000_0000};
      for (int n = 0; n < 4; n++)
      begin
         @(negedge clk);
         if (!ok && cfg_rsp.valid === 1'b1)
         begin
            ok = 1'b1;
            d = cfg_rsp.data;
         end
         if (n == 0)
            cfg_req = '{1'b0, 1'b0, ~a, 4'h0, 32'hffff_ffff};
      end
   endtask
endmodule

// [tb/bdr_regs_bench.sv]
// self-checking bench for the diagnostic and subsystem register bank
// assumes bdr_root_model as the only requester
`timescale 1ns/1ps

module bdr_regs_bench;
   import bdr_pkg::*;
   logic         clk = 1'b0;
   logic         nrst;
   logic         fundamental_reset_pin_n;
   logic         global_reset_pin_n;
   logic         shared_refclk_config;
   bdr_cfg_req_s cfg_req;
   bdr_cfg_rsp_s cfg_rsp;
   logic [7:0]   fts_send_count;
   logic [4:0]   link_number;
   logic [19:0]  base_window_addr;
   logic [15:0]  subsys_ident;
   logic [15:0]  subsys_vendor_ident;
   int           failures = 0;
   int           checks = 0;

   always #5 clk = ~clk;

   bdr_regs bdr_regs_i (.clk(clk), .nrst(nrst), .fundamental_reset_pin_n(fundamental_reset_pin_n),
      .global_reset_pin_n(global_reset_pin_n), .shared_refclk_config(shared_refclk_config),
      .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .fts_send_count(fts_send_count), .link_number(link_number),
      .base_window_addr(base_window_addr), .subsys_ident(subsys_ident),
      .subsys_vendor_ident(subsys_vendor_ident));

   bdr_root_model bdr_root_model_i (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bit          ok;
      bdr_root_model_i.cfg_read(a, d, ok);
      if (!ok)
      begin
         failures++;
         end_of_test();
      end
      else
         check(d, exp);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      nrst = 1'b0;
      fundamental_reset_pin_n = 1'b0;
      global_reset_pin_n = 1'b0;
      shared_refclk_config = 1'b0;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      fundamental_reset_pin_n = 1'b1;
      global_reset_pin_n = 1'b1;
      repeat (3) @(negedge clk);
      rd_chk(BDR_OFS_DIAG_TWO, 32'h3214_6000);
      rd_chk(BDR_OFS_SUBSYS_ALIAS, 32'h0000_0000);
      check(32'(fts_send_count), 32'h0000_0032);
      $display("defaults test done");
      bdr_root_model_i.cfg_write(BDR_OFS_BASE_WINDOW, 4'hf, 32'hffff_f000);
      rd_chk(BDR_OFS_BASE_WINDOW, 32'h0000_0000);
      check(32'(base_window_addr), 32'h0000_0000);
      bdr_root_model_i.cfg_write(BDR_OFS_DIAG_TWO, 4'hf, 32'h5a21_ffff);
      rd_chk(BDR_OFS_DIAG_TWO, 32'h5a21_7f20);
      check(32'(link_number), 32'h0000_001f);
      check(32'(fts_send_count), 32'h0000_005a);
      shared_refclk_config = 1'b1;
      repeat (2) @(negedge clk);
      check(32'(fts_send_count), 32'h0000_0021);
      bdr_root_model_i.cfg_write(BDR_OFS_BASE_WINDOW, 4'hf, 32'h1234_5678);
      rd_chk(BDR_OFS_BASE_WINDOW, 32'h1234_5000);
      check(32'(base_window_addr), 32'h0001_2345);
      $display("diagnostic and window test done");
      // slow requester from here on
      bdr_root_model_i.gap = 2;
      bdr_root_model_i.cfg_write(BDR_OFS_SUBSYS_ALIAS, 4'hf, 32'habcd_1234);
      check(32'(subsys_ident), 32'h0000_abcd);
      check(32'(subsys_vendor_ident), 32'h0000_1234);
      bdr_root_model_i.cfg_write(BDR_OFS_SUBSYS_ALIAS, 4'h4, 32'h0099_0000);
      rd_chk(BDR_OFS_SUBSYS_ALIAS, 32'hab99_1234);
      rd_chk(BDR_OFS_SUBSYS_IDENTS, 32'hab99_1234);
      bdr_root_model_i.cfg_write(BDR_OFS_SUBSYS_IDENTS, 4'h3, 32'hffff_7777);
      rd_chk(BDR_OFS_SUBSYS_ALIAS, 32'hab99_7777);
      rd_chk(8'h40, 32'h0000_0000);
      $display("alias test done");
      for (int p = 0; p < 2; p++)
      begin
         bdr_root_model_i.cfg_write(BDR_OFS_SUBSYS_ALIAS, 4'hf, 32'h5555_aaaa);
         @(negedge clk);
         if (p == 0)
            fundamental_reset_pin_n = 1'b0;
         else
            global_reset_pin_n = 1'b0;
         repeat (2) @(negedge clk);
         fundamental_reset_pin_n = 1'b1;
         global_reset_pin_n = 1'b1;
         repeat (3) @(negedge clk);
         rd_chk(BDR_OFS_DIAG_TWO, 32'h3214_6000);
         check({subsys_ident, subsys_vendor_ident}, 32'h0000_0000);
         check(32'(base_window_addr), 32'h0000_0000);
         check(32'(fts_send_count), 32'h0000_0014);
      end
      $display("reset pin test done");
      end_of_test();
   end
endmodule
